// *** rtl/efm_fir_top.sv ***
/*
  eight-cell fir mac datapath with shift-and-add output stage,
  apb register slave and a two-entry result buffer.
  assumes samples and coefficients are synchronous to pclk and that
  the apb master follows the standard setup/access sequence.
*/
// Local design decisions: the placing of the registers and the APB slave port.
// Overview of operation
// R1: eight cascaded cells feed one output stage
// R2: cell has 9x9 multiplier, decimators, 26-bit accumulator
// R3: output accumulator adds cell to itself shifted eight
// R4: enabled edge loads sample bus into all cells
// R5: disabled enable loads zeros into all cells
// R6: sample enable takes effect one clock later
// R7: samples nine-bit signed or eight-bit unsigned
// R8: signedness chosen separately for coefficients, samples
// R9: decimation gives rate one half, third, quarter
// R10: each cell does one mac per clock
// R11: accumulators hold thousand-tap sums without overflow; the code uses 26 bits where 30 are needed
// R12: devices chain through coefficient output
// R13: output stage combines partial products for wider words
// R14: coefficient enable delayed, shifts cells, high freezes
// R15: decimation select zero bypasses decimation registers
// R16: surrounding logic sets static format selects
// R17: all updates on one rising clock edge
`timescale 1ns/1ps
`default_nettype none
module efm_fir_top #(
  parameter int CELLS = efm_pkg::CELLS,
  parameter int DATA_W = efm_pkg::SAMPLE_W,
  parameter int ACC_W = efm_pkg::ACC_W
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // sample input
  input wire logic [DATA_W-1:0] sample_in_bus,
  input wire logic sample_load_enable_n,
  // coefficient input and cascade output
  input wire logic [DATA_W-1:0] coef_in_bus,
  input wire logic coef_load_enable_n,
  input wire logic [1:0] decim_select,
  output logic [DATA_W-1:0] coef_out_bus,
  // output stage result stream
  output logic out_valid,
  input wire logic out_ready,
  output logic [ACC_W-1:0] out_data
);
  // elaboration checks
  generate
    if (CELLS < 1 || CELLS > (1 << efm_pkg::CMD_SEL_W))
    begin : g_bad_cells
      $error("cell count out of range");
    end
    if (ACC_W < 2 * DATA_W + 2 + $clog2(efm_pkg::MIN_TAPS) || ACC_W > 32) // [R11]
    begin : g_bad_acc
      $error("accumulator width cannot hold thousand-tap sums");
    end
    if (ACC_W <= efm_pkg::OS_SHIFT)
    begin : g_bad_shift
      $error("accumulator narrower than output shift");
    end
  endgenerate

  localparam int SEL_W = efm_pkg::CMD_SEL_W;

  // delayed load enables
  logic sample_ld_r, sample_ld_nxt, coef_ld_r, coef_ld_nxt;
  // apb state
  logic [1:0] ctrl_r, ctrl_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic cmd_go_r, cmd_go_nxt, shadd_r, shadd_nxt, clr_r, clr_nxt;
  logic [SEL_W-1:0] sel_r, sel_nxt;
  logic stall, wr_done;
  logic [9:0] cell_idx;
  // output stage and buffer
  logic [ACC_W-1:0] os_acc_r, os_acc_nxt, os_base, cell_pick;
  logic [ACC_W-1:0] head_r, head_nxt, tail_r, tail_nxt;
  logic [1:0] cnt_r, cnt_nxt;
  logic valid_r, valid_nxt, push, pop;
  logic [DATA_W-1:0] cout_r, cout_nxt;
  // cell array
  logic [DATA_W-1:0] coef_chain [CELLS+1];
  logic [ACC_W-1:0] cell_acc [CELLS];

  // load enables are latched and act one clock later
  always_comb
  begin
    sample_ld_nxt = !sample_load_enable_n; // [R6]
    coef_ld_nxt = !coef_load_enable_n; // [R14]
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sample_ld_r <= 1'b0;
      coef_ld_r <= 1'b0;
    end
    else
    begin
      sample_ld_r <= sample_ld_nxt;
      coef_ld_r <= coef_ld_nxt;
    end
  end

  // cells share the sample bus, coefficients ripple cell to cell
  assign coef_chain[0] = coef_in_bus;

  genvar gi;
  generate
    for (gi = 0; gi < CELLS; gi++)
    begin : g_cell
      efm_mac_cell #(
        .DATA_W(DATA_W),
        .ACC_W(ACC_W)
      ) u_cell ( // [R1] [R2]
        .pclk(pclk),
        .presetn(presetn),
        .sample_ld(sample_ld_r), // [R4]
        .sample_in_bus(sample_in_bus),
        .sample_format_select(ctrl_r[efm_pkg::CTRL_SFMT_BIT]), // [R8]
        .coef_ld(coef_ld_r),
        .coef_in(coef_chain[gi]), // [R14]
        .coef_format_select(ctrl_r[efm_pkg::CTRL_CFMT_BIT]),
        .decim_select(decim_select), // [R9]
        .coef_out(coef_chain[gi+1]),
        .acc_clear(clr_r),
        .acc(cell_acc[gi])
      );
    end
  endgenerate

  // apb decode and register file
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    prdata_nxt = prdata_r;
    pready_nxt = 1'b0;
    pslverr_nxt = 1'b0;
    cmd_go_nxt = 1'b0;
    clr_nxt = 1'b0;
    sel_nxt = sel_r;
    shadd_nxt = shadd_r;
    cell_idx = paddr[11:2] - efm_pkg::CELLACC_BASE[11:2];
    // a command still on its way to the buffer counts as occupying it
    stall = pwrite && paddr == efm_pkg::CMD_ADDR &&
      (cnt_r == efm_pkg::BUF_FULL || (cnt_r == efm_pkg::BUF_ONE && cmd_go_r));
    wr_done = psel && penable && pready_r && pwrite;
    if (psel && !pready_r && !stall)
    begin
      pready_nxt = 1'b1;
      prdata_nxt = '0;
      if (paddr == efm_pkg::CTRL_ADDR)
      begin
        prdata_nxt[1:0] = ctrl_r;
      end
      else if (paddr == efm_pkg::CMD_ADDR)
      begin
        prdata_nxt[efm_pkg::CMD_SEL_LSB +: SEL_W] = sel_r;
        prdata_nxt[efm_pkg::CMD_SHADD_BIT] = shadd_r;
      end
      else if (paddr == efm_pkg::STAT_ADDR)
      begin
        prdata_nxt[efm_pkg::STAT_CNT_LSB +: 2] = cnt_r;
        prdata_nxt[efm_pkg::STAT_FULL_BIT] = cnt_r == efm_pkg::BUF_FULL;
      end
      else if (paddr == efm_pkg::OSACC_ADDR)
      begin
        prdata_nxt[ACC_W-1:0] = os_acc_r;
      end
      else if (paddr >= efm_pkg::CELLACC_BASE && paddr[1:0] == 2'h0 && cell_idx < 10'(CELLS))
      begin
        prdata_nxt[ACC_W-1:0] = cell_acc[cell_idx[SEL_W-1:0]];
      end
      else
      begin
        pslverr_nxt = 1'b1;
      end
    end
    if (wr_done && !pslverr_r)
    begin
      if (paddr == efm_pkg::CTRL_ADDR)
      begin
        ctrl_nxt = pwdata[1:0];
      end
      else if (paddr == efm_pkg::CMD_ADDR)
      begin
        cmd_go_nxt = 1'b1;
        sel_nxt = pwdata[efm_pkg::CMD_SEL_LSB +: SEL_W];
        shadd_nxt = pwdata[efm_pkg::CMD_SHADD_BIT];
        clr_nxt = pwdata[efm_pkg::CMD_CLR_BIT];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r <= efm_pkg::CTRL_RESET;
      prdata_r <= '0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      cmd_go_r <= 1'b0;
      clr_r <= 1'b0;
      sel_r <= '0;
      shadd_r <= 1'b0;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      cmd_go_r <= cmd_go_nxt;
      clr_r <= clr_nxt;
      sel_r <= sel_nxt;
      shadd_r <= shadd_nxt;
    end
  end

  // output stage: shift-and-add combining of cell results
  always_comb
  begin
    cell_pick = cell_acc[sel_r]; // [R1]
    os_base = shadd_r ? ACC_W'($signed(os_acc_r) >>> efm_pkg::OS_SHIFT) : '0; // [R3] [R13]
    os_acc_nxt = cmd_go_r ? os_base + cell_pick : os_acc_r; // [R3]
    cout_nxt = coef_chain[CELLS]; // [R12]
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      os_acc_r <= '0;
      cout_r <= '0;
    end
    else
    begin
      os_acc_r <= os_acc_nxt; // [R17]
      cout_r <= cout_nxt;
    end
  end

  // two-entry result buffer, head entry drives the stream
  always_comb
  begin
    push = cmd_go_r;
    pop = valid_r && out_ready;
    head_nxt = head_r;
    tail_nxt = tail_r;
    cnt_nxt = cnt_r;
    case (cnt_r)
      efm_pkg::BUF_EMPTY:
      begin
        if (push)
        begin
          head_nxt = os_acc_nxt;
          cnt_nxt = efm_pkg::BUF_ONE;
        end
      end
      efm_pkg::BUF_ONE:
      begin
        if (push && pop)
        begin
          head_nxt = os_acc_nxt;
        end
        else if (push)
        begin
          tail_nxt = os_acc_nxt;
          cnt_nxt = efm_pkg::BUF_FULL;
        end
        else if (pop)
        begin
          cnt_nxt = efm_pkg::BUF_EMPTY;
        end
      end
      efm_pkg::BUF_FULL:
      begin
        if (pop)
        begin
          head_nxt = tail_r;
          cnt_nxt = efm_pkg::BUF_ONE;
        end
      end
      default:
      begin
        cnt_nxt = efm_pkg::BUF_EMPTY;
      end
    endcase
    valid_nxt = cnt_nxt != efm_pkg::BUF_EMPTY;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      head_r <= '0;
      tail_r <= '0;
      cnt_r <= efm_pkg::BUF_EMPTY;
      valid_r <= 1'b0;
    end
    else
    begin
      head_r <= head_nxt;
      tail_r <= tail_nxt;
      cnt_r <= cnt_nxt;
      valid_r <= valid_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign coef_out_bus = cout_r;
  assign out_valid = valid_r;
  assign out_data = head_r;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_cmd_issue;
    cmd_go_r && shadd_r;
  endsequence
  sequence s_apb_setup;
    psel && !penable && !pready_r && !stall;
  endsequence

  a_enable_delay: assert property (!sample_load_enable_n |=> sample_ld_r) // [R6]
    else $error("sample enable not delayed by one clock");
  a_coef_delay: assert property (coef_load_enable_n |=> !coef_ld_r) // [R14]
    else $error("coefficient enable not delayed");
  a_shift_add: assert property (s_cmd_issue |=> // [R3]
    os_acc_r == ACC_W'($signed($past(os_acc_r)) >>> efm_pkg::OS_SHIFT) + $past(cell_pick))
    else $error("output stage shift-and-add wrong");
  a_apb_ready: assert property (s_apb_setup |=> pready_r ##1 !pready_r)
    else $error("apb answer timing wrong");
  a_buf_hold: assert property (valid_r && !out_ready |=> valid_r && $stable(head_r))
    else $error("buffer dropped a stalled word");
endmodule
`default_nettype wire

// *** common/efm_pkg.sv ***
/*
  constants shared by the eight-cell fir mac datapath and its cells.
  assumes a single rising-edge clock domain and an apb register slave.
*/
`default_nettype none
package efm_pkg;
  // datapath geometry
  localparam int CELLS = 8;
  localparam int SAMPLE_W = 9;
  localparam int ACC_W = 26;
  localparam int OS_SHIFT = 8;
  localparam int DREGS = 3;
  localparam int MIN_TAPS = 1024;
  localparam int BUF_DEPTH = 2;
  // apb register byte addresses
  localparam logic [11:0] CTRL_ADDR = 12'h000;
  localparam logic [11:0] CMD_ADDR = 12'h004;
  localparam logic [11:0] STAT_ADDR = 12'h008;
  localparam logic [11:0] OSACC_ADDR = 12'h00C;
  localparam logic [11:0] CELLACC_BASE = 12'h010;
  // control register fields
  localparam int CTRL_SFMT_BIT = 0;
  localparam int CTRL_CFMT_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h3;
  // command register fields
  localparam int CMD_SEL_LSB = 0;
  localparam int CMD_SEL_W = 3;
  localparam int CMD_SHADD_BIT = 3;
  localparam int CMD_CLR_BIT = 4;
  // status register fields
  localparam int STAT_CNT_LSB = 0;
  localparam int STAT_FULL_BIT = 2;
  // buffer occupancy codes
  localparam logic [1:0] BUF_EMPTY = 2'h0;
  localparam logic [1:0] BUF_ONE = 2'h1;
  localparam logic [1:0] BUF_FULL = 2'h2;
  // decimation select codes
  localparam logic [1:0] DECIM_OFF = 2'h0;
endpackage
`default_nettype wire

// *** rtl/efm_mac_cell.sv ***
/*
  one filter cell: sample register, coefficient register, three
  decimation registers, 9x9 multiplier and 26-bit accumulator.
  assumes the load enables arrive already delayed by one clock.
*/
`timescale 1ns/1ps
`default_nettype none
module efm_mac_cell #(
  parameter int DATA_W = efm_pkg::SAMPLE_W,
  parameter int ACC_W = efm_pkg::ACC_W
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // sample path
  input wire logic sample_ld,
  input wire logic [DATA_W-1:0] sample_in_bus,
  input wire logic sample_format_select,
  // coefficient path
  input wire logic coef_ld,
  input wire logic [DATA_W-1:0] coef_in,
  input wire logic coef_format_select,
  input wire logic [1:0] decim_select,
  output logic [DATA_W-1:0] coef_out,
  // accumulator
  input wire logic acc_clear,
  output logic [ACC_W-1:0] acc
);
  localparam int PW = 2 * DATA_W + 2;

  logic [DATA_W-1:0] x_r, x_nxt, c_r, c_nxt;
  logic [DATA_W-1:0] d_r [efm_pkg::DREGS];
  logic [DATA_W-1:0] d_nxt [efm_pkg::DREGS];
  logic [ACC_W-1:0] acc_r, acc_nxt;
  logic signed [DATA_W:0] xs, cs;
  logic signed [PW-1:0] prod;
  logic [ACC_W-1:0] prod_ext;

  always_comb
  begin
    x_nxt = sample_ld ? sample_in_bus : '0; // [R4] [R5]
    c_nxt = coef_ld ? coef_in : c_r; // [R14]
    for (int i = 0; i < efm_pkg::DREGS; i++)
    begin
      d_nxt[i] = d_r[i];
    end
    if (coef_ld && decim_select != efm_pkg::DECIM_OFF) // [R9] [R15]
    begin
      d_nxt[0] = c_r;
      for (int i = 1; i < efm_pkg::DREGS; i++)
      begin
        d_nxt[i] = d_r[i-1];
      end
    end
    xs = {sample_format_select & x_r[DATA_W-1], x_r}; // [R7] [R8]
    cs = {coef_format_select & c_r[DATA_W-1], c_r}; // [R8]
    prod = xs * cs; // [R2]
    prod_ext = {{(ACC_W-PW){prod[PW-1]}}, prod};
    acc_nxt = (acc_clear ? '0 : acc_r) + prod_ext; // [R10]
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      x_r <= '0;
      c_r <= '0;
      acc_r <= '0;
      for (int i = 0; i < efm_pkg::DREGS; i++)
      begin
        d_r[i] <= '0;
      end
    end
    else
    begin
      x_r <= x_nxt; // [R17]
      c_r <= c_nxt;
      acc_r <= acc_nxt;
      d_r <= d_nxt;
    end
  end

  // decimation registers only sit in the coefficient path when selected
  always_comb
  begin
    case (decim_select) // [R15]
      2'h1: coef_out = d_r[0];
      2'h2: coef_out = d_r[1];
      2'h3: coef_out = d_r[2];
      default: coef_out = c_r;
    endcase
  end

  assign acc = acc_r;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_sample_load: assert property (sample_ld |=> x_r == $past(sample_in_bus)) // [R4]
    else $error("sample not loaded");
  a_sample_zero: assert property (!sample_ld |=> x_r == '0) // [R5]
    else $error("sample not forced to zero");
  a_coef_freeze: assert property (!coef_ld |=> $stable(c_r) && $stable(d_r[0])) // [R14]
    else $error("coefficient moved while frozen");
  a_decim_bypass: assert property ((coef_ld && decim_select == 2'h0) ##1 (decim_select == 2'h0) // [R15]
    |-> coef_out == $past(coef_in))
    else $error("decimation not bypassed");
  a_mac_step: assert property (!acc_clear |=> acc_r == $past(acc_r) + $past(prod_ext)) // [R10]
    else $error("accumulator step wrong");
endmodule
`default_nettype wire

// *** sim/efm_src_model.sv ***
/*
  upstream sample source and coefficient supply for the fir datapath.
  assumes one-cycle smp_req pulses and level coef_req from the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module efm_src_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // bench requests
  input wire logic smp_req,
  input wire logic [8:0] smp_val,
  input wire logic coef_req,
  input wire logic [8:0] coef_val,
  // toward the datapath
  output logic [8:0] sample_in_bus,
  output logic sample_load_enable_n,
  output logic [8:0] coef_in_bus,
  output logic coef_load_enable_n
);
  logic lead_r;
  logic [8:0] coef_lead_r;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      lead_r <= 1'b0;
      coef_lead_r <= 9'h000;
      sample_load_enable_n <= 1'b1;
      sample_in_bus <= 9'h000;
      coef_in_bus <= 9'h000;
      coef_load_enable_n <= 1'b1;
    end
    else
    begin
      // enable low the cycle before the value
      sample_load_enable_n <= !(smp_req && !lead_r);
      lead_r <= smp_req && !lead_r;
      // value only after the enable, toggling junk otherwise
      sample_in_bus <= lead_r ? smp_val : ~sample_in_bus;
      // shift while requested, frozen otherwise
      coef_load_enable_n <= !coef_req;
      // value one clock behind the enable
      coef_lead_r <= coef_val;
      coef_in_bus <= coef_lead_r;
    end
endmodule
`default_nettype wire

// *** sim/test_eight_cell_fir_mac_datapath.sv ***
/*
  self-checking bench for the eight-cell fir mac datapath.
  assumes efm_src_model as sample and coefficient source.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) \
  begin \
    checks++; \
    if ((g) !== (e)) \
    begin \
      num_errors++; \
      $display("unexpected at %0t: got %h expected %h", $time, (g), (e)); \
    end \
  end
module test_eight_cell_fir_mac_datapath;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, out_ready = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, out_valid, err, smp_req = 0, coef_req = 0;
  logic [8:0] smp_val = 9'h000, coef_val = 9'h000, sample_in_bus, coef_in_bus, coef_out_bus, x, c;
  logic sample_load_enable_n, coef_load_enable_n;
  logic [1:0] decim_select = 2'h0;
  logic [1:0] fmt;
  logic [25:0] out_data, p, e1, e2;
  logic [25:0] got[$];
  int num_errors = 0, checks = 0, seed = 32'h6abf, n;
  always #5 pclk = ~pclk;
  efm_fir_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sample_in_bus(sample_in_bus), .sample_load_enable_n(sample_load_enable_n), .coef_in_bus(coef_in_bus),
    .coef_load_enable_n(coef_load_enable_n), .decim_select(decim_select), .coef_out_bus(coef_out_bus),
    .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data));
  efm_src_model src (.pclk(pclk), .presetn(presetn), .smp_req(smp_req), .smp_val(smp_val),
    .coef_req(coef_req), .coef_val(coef_val), .sample_in_bus(sample_in_bus),
    .sample_load_enable_n(sample_load_enable_n), .coef_in_bus(coef_in_bus),
    .coef_load_enable_n(coef_load_enable_n));
  // capture accepted results
  always @(posedge pclk)
    if (out_valid && out_ready)
      got.push_back(out_data);
  function automatic logic [25:0] prod(input logic signed [8:0] a, input logic signed [8:0] b);
    prod = a * b;
  endfunction
  function automatic logic [25:0] shadd(input logic [25:0] o, input logic [25:0] q);
    logic signed [25:0] s;
    s = $signed(o) >>> 8;
    shadd = s + q;
  endfunction
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 200)
    begin
      @(posedge pclk);
      k++;
    end
    if (k >= 200)
      num_errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(rd, e)
  endtask
  task automatic complete_run();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(efm_pkg::CTRL_ADDR, 32'h0000_0003);
    apb(1'b0, 12'h040, 32'h0000_0000);
    `CHK({err, rd}, {1'b1, 32'h0000_0000})
    for (int it = 0; it < 4; it++)
    begin
      x = 9'($random(seed));
      c = 9'($random(seed));
      fmt = ~it[1:0];
      if (!fmt[0])
        x[8] = 1'b0;
      if (!fmt[1])
        c[8] = 1'b0;
      apb(1'b1, efm_pkg::CTRL_ADDR, {30'h0, fmt});
      rdchk(efm_pkg::CTRL_ADDR, {30'h0, fmt});
      decim_select <= it[1:0];
      coef_val <= c;
      coef_req <= 1'b1;
      repeat (8 * it + 12) @(posedge pclk);
      coef_req <= 1'b0;
      repeat (4) @(posedge pclk);
      coef_val <= ~c;
      out_ready <= 1'b1;
      apb(1'b1, efm_pkg::CMD_ADDR, 32'h0000_0010);
      repeat (4) @(posedge pclk);
      got.delete();
      smp_val <= x;
      smp_req <= 1'b1;
      @(posedge pclk);
      smp_req <= 1'b0;
      repeat (6) @(posedge pclk);
      p = prod(x, c);
      for (int i = 0; i < 8; i++)
        rdchk(efm_pkg::CELLACC_BASE + 12'(4 * i), {6'h00, p});
      `CHK(coef_out_bus, c)
      out_ready <= 1'b0;
      e1 = shadd(p, p);
      e2 = shadd(e1, p);
      apb(1'b1, efm_pkg::CMD_ADDR, 32'h0000_0000);
      apb(1'b1, efm_pkg::CMD_ADDR, 32'h0000_0009);
      rdchk(efm_pkg::STAT_ADDR, 32'h0000_0006);
      fork
        apb(1'b1, efm_pkg::CMD_ADDR, 32'h0000_000A);
        repeat (40)
        begin
          @(posedge pclk);
          out_ready <= 1'($random(seed));
        end
      join
      @(posedge pclk);
      out_ready <= 1'b1;
      n = 0;
      while (got.size() < 3 && n < 50)
      begin
        @(posedge pclk);
        n++;
      end
      if (n >= 50)
        num_errors++;
      `CHK(got[0], p)
      `CHK(got[1], e1)
      `CHK(got[2], e2)
      rdchk(efm_pkg::OSACC_ADDR, {6'h00, e2});
    end
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(efm_pkg::CTRL_ADDR, 32'h0000_0003);
    rdchk(efm_pkg::STAT_ADDR, 32'h0000_0000);
    rdchk(efm_pkg::OSACC_ADDR, 32'h0000_0000);
    complete_run();
  end
  initial
  begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    complete_run();
  end
endmodule
`default_nettype wire
